// ### verilog/csf_pkg.sv
package csf_pkg;
   // ---------------------------------------------------------------
   // datapath widths
   // ---------------------------------------------------------------
   localparam int SMP_W = 16; // sample width
   localparam int FRAC = 7; // fractional guard bits
   localparam int ACC_W = 27; // sign, 3 integer guard bits, sample, fraction
   localparam int NCOEF = 11; // programmable coefficients
   localparam int NT4 = 4; // terms for full coefficients
   localparam int NT3 = 3; // terms for balance fir
   localparam int NT2 = 2; // terms for impedance post gain
   localparam logic signed [ACC_W-1:0] ACC_MAX = 27'sh0007fff;
   localparam logic signed [ACC_W-1:0] ACC_MIN = 27'sh7ff8000;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00; // operating conditions
   localparam logic [7:0] OFS_ANALOG_IMPEDANCE_SCALING = 8'h04; // impedance scaling code
   localparam logic [7:0] OFS_TXD = 8'h08; // transmit data read
   localparam logic [7:0] OFS_COEF = 8'h10; // first coefficient word
   localparam logic [7:0] OFS_LAST = 8'h38; // last coefficient word

   // coefficient indices, word k at OFS_COEF + 4k
   localparam int C_GX = 0;
   localparam int C_GR = 1;
   localparam int C_X0 = 2;
   localparam int C_X1 = 3;
   localparam int C_X2 = 4;
   localparam int C_RI = 5;
   localparam int C_B0 = 6;
   localparam int C_B1 = 7;
   localparam int C_BI = 8;
   localparam int C_ZI = 9;
   localparam int C_ZP = 10;

   // operating condition bits
   localparam int B_CTP = 0; // cutoff_transmit_path
   localparam int B_CRP = 1; // cutoff_receive_path
   localparam int B_HPD = 2; // highpass_disable
   localparam int B_LOSS = 3; // receive_loss_6db
   localparam int B_ATI = 4; // arm_transmit_irq
   localparam int B_TLB = 5; // slot_assigner_loopback
   localparam int B_FDL = 6; // full_digital_loopback
   localparam int B_TON = 7; // receive_milliwatt_inject

   // ---------------------------------------------------------------
   // reset values and fixed constants
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [4:0] ANALOG_IMPEDANCE_SCALING_RST = 5'h00;
   localparam logic [4:0] ANALOG_IMPEDANCE_SCALING_LOOP = 5'h10; // code that forces loopback
   localparam logic [15:0] COEF_RST = 16'h7777; // about +0.0079
   localparam logic [15:0] HP_COEF = 16'h0d77; // about 0.969 pole
   localparam int TONE_LEN = 8; // 1 kHz at 8 kHz sample rate
   localparam logic [TONE_LEN-1:0][15:0] TONE_TAB = {
      16'he1c9, 16'hd765, 16'he1c9, 16'h0000,
      16'h1e37, 16'h289b, 16'h1e37, 16'h0000};
endpackage

// ### verilog/csf_filter_core.sv
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - multiply by shift and add only
// - fir sums current and n past samples
// - single pole recursion for impedance, balance
// - receive iir differences input then recurses
// - shifts relative, signs multiply cumulatively
// - each term is a four bit nibble
// - three bit shift code, zero to seven
// - term one is most significant
// - four, three or two terms per filter
// - transmit gain is one plus coefficient
// - range set by term count
// - transmit cutoff floats outputs, beats loopbacks
// - receive cutoff zeroes receive after gain and loss
// - highpass disable bypasses transmit highpass
// - receive loss adds 6.02 dB attenuation
// - armed interrupt on new data, read clears
// - slot loopback copies receive to transmit
// - full loopback feeds output to input
// - impedance code 10000 enters full loopback
// - tone replaces slot receive data in the receive filter path; slot loopback still copies the slot data
// - data read returns byte and old flag
module csf_filter_core
   import csf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_tick,
   input wire logic slot_tick,
   input wire logic [15:0] pcm_rx_sample,
   input wire logic [15:0] analog_in_pin,
   output logic [15:0] pcm_transmit_output,
   output logic pcm_transmit_output_oe,
   output logic transmit_slot_strobe_n,
   output logic transmit_slot_strobe_oe,
   output logic [15:0] analog_out_pin,
   output logic analog_out_en,
   output logic tx_irq
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl; // operating conditions
      logic [4:0] analog_impedance_scaling; // impedance scaling code
      logic [NCOEF-1:0][15:0] coef; // coefficient words
      logic [2:0] tone_ph; // milliwatt table phase
      logic [15:0] r_x1; // receive iir previous input
      logic [15:0] r_y1; // receive iir previous output
      logic [15:0] z_y1; // impedance iir previous output
      logic [15:0] tin1; // previous transmit input
      logic [15:0] b_x1; // balance fir delay
      logic [15:0] b_y1; // balance iir previous output
      logic [15:0] hp_x1; // highpass previous input
      logic [15:0] hp_y1; // highpass previous output
      logic [15:0] x1; // transmit fir delay one
      logic [15:0] x2; // transmit fir delay two
      logic [15:0] tx_word; // newest transmit sample
      logic tx_old; // transmit sample already read
      logic irq; // interrupt level
      logic [15:0] aout; // analog output sample
      logic [15:0] ptx; // pcm slot data
      logic strobe; // slot strobe active
      logic [31:0] rdata; // read data
   } csf_state_t;

   csf_state_t s_reg;
   csf_state_t s_next;

   // ---------------------------------------------------------------
   // arithmetic helpers
   // ---------------------------------------------------------------
   // widen a sample into accumulator units
   function automatic logic signed [ACC_W-1:0] ext(input logic [15:0] x);
      ext = ACC_W'($signed(x)) <<< FRAC;
   endfunction

   // back to a sample, clipped rather than wrapped
   function automatic logic [15:0] sat(input logic signed [ACC_W-1:0] a);
      logic signed [ACC_W-1:0] v;
      v = a >>> FRAC;
      if (v > ACC_MAX) begin
         sat = 16'h7fff;
      end else if (v < ACC_MIN) begin
         sat = 16'h8000;
      end else begin
         sat = v[15:0];
      end
   endfunction

   // signed-digit product, no multiplier: one shift and add per term
   function automatic logic signed [ACC_W-1:0] canonic_signed_digit(
      input logic [15:0] x,
      input logic [15:0] c,
      input int n
   );
      logic signed [ACC_W-1:0] acc;
      logic signed [ACC_W-1:0] base;
      logic neg;
      logic [4:0] sh;
      acc = '0;
      base = ext(x);
      neg = 1'b0;
      sh = 5'h00;
      for (int k = 0; k < NT4; k++) begin
         // term one sits in the top nibble, later terms below it
         if (k < n) begin
            neg = neg ^ c[15-4*k];
            sh = sh + {2'b00, c[14-4*k -: 3]};
            if (neg) begin
               acc = acc - (base >>> sh);
            end else begin
               acc = acc + (base >>> sh);
            end
         end
      end
      // four terms cannot exceed four times the sample: guard bits hold it
      canonic_signed_digit = acc;
   endfunction

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic setup; // first cycle of a transfer
   logic acc_ph; // access cycle, completes now
   logic hit; // address is mapped
   logic [3:0] cidx; // coefficient index
   logic txd_rd; // transmit data read completes

   assign setup = psel & ~penable;
   assign acc_ph = psel & penable;
   assign cidx = 4'(({2'b00, paddr[7:2]} - {2'b00, OFS_COEF[7:2]}));
   assign hit = (paddr[1:0] == 2'b00) &&
      (paddr == OFS_CTRL || paddr == OFS_ANALOG_IMPEDANCE_SCALING || paddr == OFS_TXD ||
      (paddr >= OFS_COEF && paddr <= OFS_LAST));
   assign txd_rd = acc_ph & ~pwrite & (paddr == OFS_TXD);
   // always ready: read data was latched during setup
   assign pready = 1'b1;
   assign pslverr = acc_ph & ~hit;

   // ---------------------------------------------------------------
   // sample path signals
   // ---------------------------------------------------------------
   logic full_digital_loopback; // full loopback active
   logic [15:0] rx_src; // slot data or tone
   logic [15:0] r_y; // receive iir output
   logic [15:0] gr; // receive gain output
   logic [15:0] lo; // after optional loss
   logic [15:0] rxs; // receive after cutoff
   logic [15:0] zy; // impedance iir output
   logic [15:0] zo; // impedance post gain
   logic [15:0] aout; // analog output sample
   logic [15:0] tx_in; // transmit input
   logic [15:0] bal; // balance estimate
   logic [15:0] tb; // transmit after balance
   logic [15:0] hy; // highpass output
   logic [15:0] ho; // highpass or bypass
   logic [15:0] gx; // transmit gain output
   logic [15:0] xo; // transmit fir output
   logic [15:0] tw; // final transmit word

   // ---------------------------------------------------------------
   // datapath and next state
   // ---------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      // loopback by bit or by the special scaling code
      full_digital_loopback = s_reg.ctrl[B_FDL] | (s_reg.analog_impedance_scaling == ANALOG_IMPEDANCE_SCALING_LOOP);
      // tone takes the place of slot data
      if (s_reg.ctrl[B_TON]) begin
         rx_src = TONE_TAB[s_reg.tone_ph];
      end else begin
         rx_src = pcm_rx_sample;
      end
      // difference, then recursion on the previous output
      r_y = sat(ext(rx_src) - ext(s_reg.r_x1) +
         canonic_signed_digit(s_reg.r_y1, s_reg.coef[C_RI], NT4));
      gr = sat(canonic_signed_digit(r_y, s_reg.coef[C_GR], NT4));
      // one arithmetic shift halves the level: exactly 6.02 dB
      lo = s_reg.ctrl[B_LOSS] ? {gr[15], gr[15:1]} : gr;
      // zero here also silences tone, full loopback and balance paths
      rxs = s_reg.ctrl[B_CRP] ? 16'h0000 : lo;
      // impedance path uses last sample to avoid a combinational loop
      zy = sat(ext(s_reg.tin1) + canonic_signed_digit(s_reg.z_y1, s_reg.coef[C_ZI], NT4));
      zo = sat(canonic_signed_digit(zy, s_reg.coef[C_ZP], NT2));
      // impedance path suspended during full loopback
      if (full_digital_loopback) begin
         aout = rxs;
         tx_in = aout;
      end else begin
         aout = sat(ext(rxs) + ext(zo));
         tx_in = analog_in_pin;
      end
      // balance: two tap fir of three terms, then single pole
      bal = sat(canonic_signed_digit(rxs, s_reg.coef[C_B0], NT3) +
         canonic_signed_digit(s_reg.b_x1, s_reg.coef[C_B1], NT3) +
         canonic_signed_digit(s_reg.b_y1, s_reg.coef[C_BI], NT4));
      tb = sat(ext(tx_in) - ext(bal));
      // fixed dc-blocking highpass in the transmit path
      hy = sat(ext(tb) - ext(s_reg.hp_x1) + canonic_signed_digit(s_reg.hp_y1, HP_COEF, NT4));
      ho = s_reg.ctrl[B_HPD] ? tb : hy;
      gx = sat(ext(ho) + canonic_signed_digit(ho, s_reg.coef[C_GX], NT4));
      xo = sat(canonic_signed_digit(gx, s_reg.coef[C_X0], NT4) +
         canonic_signed_digit(s_reg.x1, s_reg.coef[C_X1], NT4) +
         canonic_signed_digit(s_reg.x2, s_reg.coef[C_X2], NT4));
      // slot loopback overwrites whatever the filters made
      tw = s_reg.ctrl[B_TLB] ? pcm_rx_sample : xo;

      // bus read latched in setup so prdata comes from a flop
      if (setup) begin
         s_next.rdata = 32'h0000_0000;
         if (paddr == OFS_CTRL) begin
            s_next.rdata[7:0] = s_reg.ctrl;
         end else if (paddr == OFS_ANALOG_IMPEDANCE_SCALING) begin
            s_next.rdata[4:0] = s_reg.analog_impedance_scaling;
         end else if (paddr == OFS_TXD) begin
            // upper byte, then flag byte with old in its bit 0
            s_next.rdata[7:0] = s_reg.tx_word[15:8];
            s_next.rdata[8] = s_reg.tx_old;
         end else if (hit) begin
            s_next.rdata[15:0] = s_reg.coef[cidx];
         end
      end
      // writes take effect at the completing edge
      if (acc_ph && pwrite && hit) begin
         if (paddr == OFS_CTRL) begin
            s_next.ctrl = pwdata[7:0];
         end else if (paddr == OFS_ANALOG_IMPEDANCE_SCALING) begin
            s_next.analog_impedance_scaling = pwdata[4:0];
         end else if (paddr != OFS_TXD) begin
            s_next.coef[cidx] = pwdata[15:0];
         end
      end
      // reading the data marks it old and drops the interrupt
      if (txd_rd) begin
         s_next.tx_old = 1'b1;
         s_next.irq = 1'b0;
      end

      // one sample per tick; new data wins over a same-cycle read
      if (sample_tick) begin
         s_next.tone_ph = s_reg.tone_ph + 3'h1;
         s_next.r_x1 = rx_src;
         s_next.r_y1 = r_y;
         s_next.z_y1 = full_digital_loopback ? 16'h0000 : zy;
         s_next.tin1 = tx_in;
         s_next.b_x1 = rxs;
         s_next.b_y1 = bal;
         s_next.hp_x1 = tb;
         s_next.hp_y1 = hy;
         s_next.x1 = gx;
         s_next.x2 = s_reg.x1;
         s_next.tx_word = tw;
         s_next.aout = aout;
         s_next.tx_old = 1'b0;
         s_next.irq = s_reg.ctrl[B_ATI];
      end

      // slot only exists while the transmit path is not cut off
      s_next.strobe = 1'b0;
      if (slot_tick && !s_reg.ctrl[B_CTP]) begin
         s_next.ptx = s_reg.tx_word;
         s_next.strobe = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.ctrl <= CTRL_RST;
         s_reg.analog_impedance_scaling <= ANALOG_IMPEDANCE_SCALING_RST;
         s_reg.coef <= {NCOEF{COEF_RST}};
         s_reg.tx_old <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata = s_reg.rdata;
   assign pcm_transmit_output = s_reg.ptx;
   // cutoff floats both pins whatever loopback is set
   assign pcm_transmit_output_oe = ~s_reg.ctrl[B_CTP];
   assign transmit_slot_strobe_oe = ~s_reg.ctrl[B_CTP];
   // a slot registered just before cutoff landed must not pulse
   assign transmit_slot_strobe_n = ~(s_reg.strobe & ~s_reg.ctrl[B_CTP]);
   assign analog_out_pin = s_reg.aout;
   assign analog_out_en = ~full_digital_loopback;
   assign tx_irq = s_reg.irq;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ctp_float;
      s_reg.ctrl[B_CTP] |-> !pcm_transmit_output_oe && !transmit_slot_strobe_oe
         && transmit_slot_strobe_n;
   endproperty
   a_ctp_float: assert property (p_ctp_float)
      else $error("transmit pins driven during cutoff");

   property p_crp_zero;
      sample_tick && s_reg.ctrl[B_CRP] && !full_digital_loopback |=> s_reg.b_x1 == 16'h0000;
   endproperty
   a_crp_zero: assert property (p_crp_zero)
      else $error("receive not zeroed during cutoff");

   property p_hpd;
      sample_tick && s_reg.ctrl[B_HPD] |=> s_reg.x1 == $past(gx) &&
         $past(ho) == $past(tb);
   endproperty
   a_hpd: assert property (p_hpd)
      else $error("highpass not bypassed");

   property p_loss;
      s_reg.ctrl[B_LOSS] && !s_reg.ctrl[B_CRP] |-> lo == {gr[15], gr[15:1]};
   endproperty
   a_loss: assert property (p_loss)
      else $error("receive loss not applied");

   property p_irq_set;
      sample_tick && s_reg.ctrl[B_ATI] |=> tx_irq && !s_reg.tx_old;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("interrupt not raised on new data");

   property p_irq_clr;
      txd_rd && !sample_tick |=> !tx_irq && s_reg.tx_old;
   endproperty
   a_irq_clr: assert property (p_irq_clr)
      else $error("read did not clear interrupt");

   property p_tlb;
      sample_tick && s_reg.ctrl[B_TLB] |=> s_reg.tx_word == $past(pcm_rx_sample);
   endproperty
   a_tlb: assert property (p_tlb)
      else $error("slot loopback data wrong");

   property p_analog_impedance_scaling_loop;
      acc_ph && pwrite && paddr == OFS_ANALOG_IMPEDANCE_SCALING && pwdata[4:0] == ANALOG_IMPEDANCE_SCALING_LOOP
         |=> !analog_out_en;
   endproperty
   a_analog_impedance_scaling_loop: assert property (p_analog_impedance_scaling_loop)
      else $error("scaling code did not enter loopback");

   property p_tone;
      sample_tick && s_reg.ctrl[B_TON] |=> s_reg.r_x1 == $past(TONE_TAB[s_reg.tone_ph]);
   endproperty
   a_tone: assert property (p_tone)
      else $error("tone not injected");

   property p_txd_read;
      setup && !pwrite && paddr == OFS_TXD |=> prdata[8] == $past(s_reg.tx_old)
         && prdata[7:0] == $past(s_reg.tx_word[15:8]);
   endproperty
   a_txd_read: assert property (p_txd_read)
      else $error("transmit data read wrong");

   c_irq: cover property (sample_tick && s_reg.ctrl[B_ATI] ##1 txd_rd);
   c_fdl: cover property (full_digital_loopback && sample_tick);
   c_slot: cover property (slot_tick && !s_reg.ctrl[B_CTP] && s_reg.ctrl[B_TLB]);
endmodule

// ### verification/csf_host.sv
`timescale 1ns/1ps
// ---------------------------------------------
// host model: apb master and coefficient coder
// ---------------------------------------------
module csf_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // one term: sign on top, shift count below
   function automatic logic [3:0] term(input logic neg, input logic [2:0] sh);
      return {neg, sh};
   endfunction

   // four terms, most significant one first
   function automatic logic [15:0] coef4(input logic [3:0] t1, t2, t3, t4);
      return {t1, t2, t3, t4};
   endfunction

   // setup then access; held until pready seen high, no fixed wait
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench
   import csf_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic sample_tick, slot_tick, analog_out_en, tx_irq;
   logic [15:0] pcm_rx_sample, analog_in_pin, pcm_transmit_output, analog_out_pin;
   logic pcm_transmit_output_oe, transmit_slot_strobe_n, transmit_slot_strobe_oe;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [64:0] notes[$]; // {error, mask, data} per transfer
   logic [64:0] note;
   logic [15:0] cv[NCOEF];
   logic [15:0] s1, d16; // previous receive sample, expected output

   csf_filter_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sample_tick, .slot_tick, .pcm_rx_sample,
      .analog_in_pin, .pcm_transmit_output, .pcm_transmit_output_oe,
      .transmit_slot_strobe_n, .transmit_slot_strobe_oe, .analog_out_pin,
      .analog_out_en, .tx_irq);
   csf_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);

   // ---------------------------------------------
   // reporting
   // ---------------------------------------------
   task automatic bad(input string s);
      mismatches++;
      $display("BAD %0t %s", $time, s);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      tests_run++;
      if (g !== e) bad(s);
   endtask
   // clipped difference of two samples: receive iir with a zero pole
   function automatic logic [15:0] dif(input logic [15:0] a, input logic [15:0] b);
      int d;
      d = int'($signed(a)) - int'($signed(b));
      if (d > 32767) d = 32767;
      if (d < -32768) d = -32768;
      return 16'(d);
   endfunction
   task automatic summarize;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ---------------------------------------------
   // drivers: note expectation, then run the bus
   // ---------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
      notes.push_back({e, 32'h0, 32'h0});
      host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0,
         input logic [31:0] m = 32'hffffffff);
      notes.push_back({e, m, d});
      host.xfer(1'b0, a, 32'h0);
   endtask
   // one-cycle strobe with fresh random samples; returns at settled point
   task automatic tick(input logic smp);
      @(posedge pclk);
      if (smp) sample_tick <= 1'b1;
      else slot_tick <= 1'b1;
      pcm_rx_sample <= 16'($urandom);
      analog_in_pin <= 16'($urandom);
      @(posedge pclk);
      sample_tick <= 1'b0;
      slot_tick <= 1'b0;
      @(negedge pclk);
   endtask

   // ---------------------------------------------
   // monitor: oldest note against each completion
   // ---------------------------------------------
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (notes.size() == 0) begin
            bad("transfer with no note");
         end else begin
            note = notes.pop_front();
            tests_run++;
            if (pslverr !== note[64] || (prdata & note[63:32]) !== note[31:0]) begin
               bad("apb response");
            end
         end
      end
   end

   // clock and hang guard; the whole run is well under this ceiling
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         summarize();
      end
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      presetn = 1'b0;
      sample_tick = 1'b0;
      slot_tick = 1'b0;
      pcm_rx_sample = 16'h0;
      analog_in_pin = 16'h0;
      void'($urandom(32'h8f1d));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(pcm_transmit_output_oe, 1, "oe reset");
      chk(transmit_slot_strobe_n, 1, "strobe reset");
      chk(analog_out_en, 1, "out enable reset");
      chk(tx_irq, 0, "irq reset");
      rd(OFS_CTRL, 32'(CTRL_RST));
      rd(OFS_ANALOG_IMPEDANCE_SCALING, 32'(ANALOG_IMPEDANCE_SCALING_RST));
      rd(OFS_TXD, 32'h100);
      for (int k = 0; k < NCOEF; k++) rd(OFS_COEF + 8'(4 * k), 32'(COEF_RST));
      // refused places, write must not land
      rd(8'h0c, 0, 1'b1);
      rd(8'h3c, 0, 1'b1);
      rd(8'h01, 0, 1'b1);
      wr(8'h40, 32'hff, 1'b1);
      rd(OFS_CTRL, 0);
      // coefficients: three coded from terms, rest random; upper bits read 0
      cv[0] = host.coef4(host.term(0, 0), host.term(1, 1), host.term(0, 2), host.term(1, 7));
      for (int k = 1; k < NCOEF; k++) cv[k] = 16'($urandom);
      // unity receive gain (1 + 1 - 1/2 - 1/2) and a zero pole (1 - 1 + 1 - 1)
      cv[C_GR] = host.coef4(host.term(0, 0), host.term(0, 0), host.term(1, 1),
         host.term(0, 0));
      cv[C_RI] = host.coef4(host.term(0, 0), host.term(1, 0), host.term(1, 0),
         host.term(1, 0));
      for (int k = 0; k < NCOEF; k++) wr(OFS_COEF + 8'(4 * k), {16'($urandom), cv[k]});
      for (int k = 0; k < NCOEF; k++) rd(OFS_COEF + 8'(4 * k), 32'(cv[k]));
      // every condition bit alone
      for (int b = 0; b < 8; b++) begin
         wr(OFS_CTRL, 32'h1 << b);
         rd(OFS_CTRL, 32'h1 << b);
      end
      // impedance code: neighbour value stays out of loopback
      wr(OFS_CTRL, 0);
      wr(OFS_ANALOG_IMPEDANCE_SCALING, 32'hffffffef);
      rd(OFS_ANALOG_IMPEDANCE_SCALING, 32'h0f);
      @(negedge pclk);
      chk(analog_out_en, 1, "out on at code 0f");
      wr(OFS_ANALOG_IMPEDANCE_SCALING, 32'(ANALOG_IMPEDANCE_SCALING_LOOP));
      @(negedge pclk);
      chk(analog_out_en, 0, "out off at loop code");
      wr(OFS_ANALOG_IMPEDANCE_SCALING, 0);
      wr(OFS_CTRL, 32'h1 << B_FDL);
      @(negedge pclk);
      chk(analog_out_en, 0, "out off in full loopback");
      // cutoff beats both loopbacks: floated, no slot strobe
      wr(OFS_CTRL, (32'h1 << B_CTP) | (32'h1 << B_TLB) | (32'h1 << B_FDL));
      @(negedge pclk);
      chk(pcm_transmit_output_oe, 0, "data floats");
      chk(transmit_slot_strobe_oe, 0, "strobe floats");
      tick(1'b0);
      chk(transmit_slot_strobe_n, 1, "no slot in cutoff");
      // slot without cutoff: one low cycle after slot_tick
      wr(OFS_CTRL, 32'h1 << B_TLB);
      @(negedge pclk);
      chk(transmit_slot_strobe_oe, 1, "strobe driven");
      tick(1'b0);
      chk(transmit_slot_strobe_n, 0, "slot strobe low");
      @(negedge pclk);
      chk(transmit_slot_strobe_n, 1, "slot strobe one cycle");
      // armed interrupt: new data raises, read clears and marks old
      wr(OFS_CTRL, 32'h1 << B_ATI);
      tick(1'b1);
      chk(tx_irq, 1, "irq on new data");
      rd(OFS_TXD, 0, 1'b0, 32'hffffff00);
      @(negedge pclk);
      chk(tx_irq, 0, "irq cleared by read");
      rd(OFS_TXD, 32'h100, 1'b0, 32'hffffff00);
      // unarmed: flag still new, no interrupt
      wr(OFS_CTRL, 0);
      tick(1'b1);
      chk(tx_irq, 0, "irq while unarmed");
      rd(OFS_TXD, 0, 1'b0, 32'hffffff00);
      // full loopback: output is the differenced receive sample, then halved, then cut
      wr(OFS_CTRL, 32'h1 << B_FDL);
      tick(1'b1);
      for (int i = 0; i < 3; i++) begin
         s1 = pcm_rx_sample;
         if (i == 1) wr(OFS_CTRL, (32'h1 << B_FDL) | (32'h1 << B_LOSS));
         if (i == 2) wr(OFS_CTRL, (32'h1 << B_FDL) | (32'h1 << B_CRP));
         tick(1'b1);
         d16 = dif(pcm_rx_sample, s1);
         if (i == 1) d16 = 16'($signed(d16) >>> 1);
         if (i == 2) d16 = 16'h0000;
         chk(analog_out_pin, d16, "loopback output");
      end
      // slot loopback: the received sample leaves in the next slot
      wr(OFS_CTRL, 32'h1 << B_TLB);
      tick(1'b1);
      s1 = pcm_rx_sample;
      tick(1'b0);
      chk(pcm_transmit_output, s1, "slot loopback data");
      // random conditions with traffic; transmit stays driven
      for (int i = 0; i < 16; i++) begin
         wr(OFS_CTRL, {24'h0, 7'($urandom), 1'b0});
         tick(1'b1);
         tick(1'b0);
         chk(pcm_transmit_output_oe, 1, "driven without cutoff");
      end
      @(negedge pclk);
      chk(32'(notes.size()), 0, "notes left over");
      summarize();
   end
endmodule
